// file: verilog/timer_counter_8bit.sv
// 8-bit up timer/counter with auto-reload, buzzer toggle and PWM output
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module timer_counter_8bit
	import tc_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Clock source pulses
	input wire logic cpu_tick,
	input wire logic osc_tick,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	// External event pin
	input wire logic external_event_pin,
	output logic event_pin_request_flag,
	// Buzzer / PWM pin
	output logic buzzer_output_pin,
	output logic buzzer_output_pin_oe,
	// Events
	output logic timeout,
	output logic green_wake
);
	reg_req_t req;
	mode_reg_t mode;
	shared_reg_t shared;
	logic [DATA_W-1:0] count;
	logic [DATA_W-1:0] reload_value_register;
	logic buzzer_level;

	logic [DATA_W-1:0] next_count;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] bound;
	logic [DATA_W-1:0] reload_target;
	logic [3:0] presc_exp;
	logic presc_src;
	logic presc_run;
	logic presc_tick;
	logic pin_fall;
	logic tick;
	logic at_bound;
	logic overflow;
	logic wr_shared;
	logic wr_mode;
	logic wr_count;
	logic wr_reload;
	logic pwm_level;
	logic pin_driven;

	function automatic logic [DATA_W-1:0] pwm_bound(input logic rl, input logic tg);
		logic [DATA_W-1:0] b;
		b = PWM_BOUND_00;
		if (rl && tg) begin
			b = PWM_BOUND_11;
		end else if (rl) begin
			b = PWM_BOUND_10;
		end else if (tg) begin
			b = PWM_BOUND_01;
		end
		return b;
	endfunction

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// Address decoding
	assign wr_shared = req.wr && (req.addr == ADDR_SHARED);
	assign wr_mode = req.wr && (req.addr == ADDR_MODE);
	assign wr_count = req.wr && (req.addr == ADDR_COUNT);
	assign wr_reload = req.wr && (req.addr == ADDR_RELOAD);
	assign next_rdata = !req.rd ? READ_ZERO :
		(req.addr == ADDR_SHARED) ? shared :
		(req.addr == ADDR_MODE) ? mode :
		(req.addr == ADDR_COUNT) ? count : READ_ZERO;

	// Clock source selection
	assign presc_src = shared.fast_clock_select ? osc_tick : cpu_tick;
	assign presc_exp = shared.fast_clock_select ?
		EXP_OSC_BASE - {1'b0, mode.prescale_rate_field} :
		EXP_CPU_BASE - {1'b0, mode.prescale_rate_field};
	assign presc_run = mode.count_enable && !mode.source_select;

	tc_prescaler #(
		.W(PRESC_W)
	) u_presc (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.run(presc_run),
		.src_tick(presc_src),
		.exponent(presc_exp),
		.tick(presc_tick)
	);

	tc_edge_detect u_edge (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.pin(external_event_pin),
		.fall(pin_fall)
	);

	// Tick from selected source, gated by enable
	assign tick = mode.count_enable &&
		(mode.source_select ? pin_fall : presc_tick);

	// Overflow point
	assign bound = mode.pwm_output_enable ?
		pwm_bound(mode.reload_control, mode.toggle_output_enable) : COUNT_MAX;
	assign at_bound = (count & bound) == bound;
	assign overflow = tick && at_bound;

	// PWM wraps to zero; otherwise reload or zero
	assign reload_target = (!mode.pwm_output_enable && mode.reload_control) ?
		reload_value_register : COUNT_ZERO;
	assign next_count = wr_count ? req.wdata :
		overflow ? reload_target :
		tick ? count + COUNT_ONE : count;

	// Duty from reload register within the PWM cycle
	assign pwm_level = (count & bound) < (reload_value_register & bound);
	assign pin_driven = mode.count_enable &&
		(mode.pwm_output_enable || mode.toggle_output_enable);

	// Registers
	always_ff @(posedge clk) begin
		if (reset) begin
			mode <= RESET_VALUE;
			shared <= RESET_VALUE;
			reload_value_register <= RESET_VALUE;
		end else if (clk_en) begin
			if (wr_mode) begin
				mode <= req.wdata;
			end
			if (wr_shared) begin
				shared <= req.wdata;
			end
			if (wr_reload) begin
				reload_value_register <= req.wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count <= RESET_VALUE;
			rdata <= READ_ZERO;
		end else if (clk_en) begin
			count <= next_count;
			rdata <= next_rdata;
		end
	end

	// Events and pin
	always_ff @(posedge clk) begin
		if (reset) begin
			timeout <= 1'b0;
			green_wake <= 1'b0;
			event_pin_request_flag <= 1'b0;
			buzzer_level <= 1'b0;
		end else if (clk_en) begin
			timeout <= overflow;
			green_wake <= overflow && shared.green_wake_enable;
			event_pin_request_flag <= pin_fall && !mode.source_select;
			if (overflow && !mode.pwm_output_enable && mode.toggle_output_enable) begin
				buzzer_level <= ~buzzer_level;
			end
		end else begin
			timeout <= 1'b0;
			green_wake <= 1'b0;
			event_pin_request_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			buzzer_output_pin <= 1'b0;
			buzzer_output_pin_oe <= 1'b0;
		end else if (clk_en) begin
			buzzer_output_pin <= mode.pwm_output_enable ? pwm_level : buzzer_level;
			buzzer_output_pin_oe <= pin_driven;
		end
	end

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Counting and overflow
	a_count_step: assert property (clk_en && tick && !at_bound && !wr_count
		|=> count == $past(count) + COUNT_ONE)
		else $error("counter did not step by one");
	a_max_wrap: assert property (clk_en && tick && !mode.pwm_output_enable
		&& !mode.reload_control && count == COUNT_MAX && !wr_count
		|=> timeout && count == COUNT_ZERO)
		else $error("no wrap from maximum");
	a_no_early_wrap: assert property (clk_en && tick && !mode.pwm_output_enable
		&& count != COUNT_MAX |=> !timeout)
		else $error("time-out before maximum");
	a_wrap_zero: assert property (clk_en && overflow && !wr_count
		&& !mode.reload_control |=> count == COUNT_ZERO)
		else $error("wrap did not reach zero");
	a_timeout_pulse: assert property (clk_en && overflow
		|=> timeout)
		else $error("overflow without time-out");
	a_timeout_only: assert property (clk_en && !overflow
		|=> !timeout)
		else $error("time-out without overflow");
	a_disabled_hold: assert property (clk_en && !mode.count_enable && !wr_count
		|=> $stable(count))
		else $error("counter moved while disabled");
	a_disabled_quiet: assert property (clk_en && !mode.count_enable
		|=> !timeout)
		else $error("time-out while disabled");

	// Event pin
	a_event_req_quiet: assert property (clk_en && mode.source_select
		|=> !event_pin_request_flag)
		else $error("event pin request while event counting");
	a_req_on_fall: assert property (clk_en && pin_fall && !mode.source_select
		|=> event_pin_request_flag)
		else $error("pin fall not flagged");
	a_event_counts: assert property (clk_en && mode.count_enable && mode.source_select
		&& pin_fall && !at_bound && !wr_count |=> count == $past(count) + COUNT_ONE)
		else $error("falling edge not counted");
	a_presc_ignored: assert property (clk_en && mode.source_select && !pin_fall
		&& !wr_count |=> $stable(count))
		else $error("counter moved without pin edge");

	// Reload and PWM cycle
	a_reload_copy: assert property (clk_en && overflow && !wr_count
		&& !mode.pwm_output_enable && mode.reload_control
		|=> count == $past(reload_value_register))
		else $error("reload not copied on overflow");
	a_pwm_bound: assert property (clk_en && tick && mode.pwm_output_enable
		&& !mode.reload_control && mode.toggle_output_enable
		&& (count == PWM_BOUND_01) && !wr_count |=> count == COUNT_ZERO)
		else $error("PWM cycle 0-63 did not wrap");
	a_pwm_wrap_16: assert property (clk_en && tick && mode.pwm_output_enable
		&& mode.reload_control && mode.toggle_output_enable
		&& (count == PWM_BOUND_11) && !wr_count |=> count == COUNT_ZERO)
		else $error("PWM cycle 0-15 did not wrap");
	a_pwm_wrap_32: assert property (clk_en && tick && mode.pwm_output_enable
		&& mode.reload_control && !mode.toggle_output_enable
		&& (count == PWM_BOUND_10) && !wr_count |=> count == COUNT_ZERO)
		else $error("PWM cycle 0-31 did not wrap");
	a_pwm_wrap_256: assert property (clk_en && tick && mode.pwm_output_enable
		&& !mode.reload_control && !mode.toggle_output_enable
		&& (count == PWM_BOUND_00) && !wr_count |=> count == COUNT_ZERO)
		else $error("PWM cycle 0-255 did not wrap");
	a_pwm_no_reload: assert property (clk_en && overflow && mode.pwm_output_enable
		&& !wr_count |=> count == COUNT_ZERO)
		else $error("PWM overflow did not restart cycle");

	// Wake, buzzer and pin ownership
	a_wake_gate: assert property (clk_en && overflow && !shared.green_wake_enable
		|=> !green_wake)
		else $error("wake with wake disabled");
	a_wake_on: assert property (clk_en && overflow && shared.green_wake_enable
		|=> green_wake)
		else $error("no wake with wake enabled");
	a_buzz_toggle: assert property (clk_en && overflow && !mode.pwm_output_enable
		&& mode.toggle_output_enable |=> buzzer_level != $past(buzzer_level))
		else $error("buzzer did not toggle");
	a_buzz_hold: assert property (clk_en && !overflow
		|=> $stable(buzzer_level))
		else $error("buzzer changed without time-out");
	a_toggle_owns: assert property (clk_en && mode.count_enable
		&& !mode.pwm_output_enable && mode.toggle_output_enable |=> buzzer_output_pin_oe)
		else $error("toggle output not driving pin");
	a_pin_released: assert property (clk_en && !mode.pwm_output_enable
		&& !mode.toggle_output_enable |=> !buzzer_output_pin_oe)
		else $error("pin driven with outputs off");
	a_pwm_owns: assert property (clk_en && mode.count_enable
		&& mode.pwm_output_enable |=> buzzer_output_pin_oe)
		else $error("PWM output not driving pin");

	// Register port
	a_read_count: assert property (clk_en && req.rd && req.addr == ADDR_COUNT
		|=> rdata == $past(count))
		else $error("count readback wrong");
	a_read_mode: assert property (clk_en && req.rd && req.addr == ADDR_MODE
		|=> rdata == $past(mode))
		else $error("mode readback wrong");
	a_read_shared: assert property (clk_en && req.rd && req.addr == ADDR_SHARED
		|=> rdata == $past(shared))
		else $error("shared readback wrong");
	a_read_reload: assert property (clk_en && req.rd && req.addr == ADDR_RELOAD
		|=> rdata == READ_ZERO)
		else $error("reload register readable");
	a_rdata_idle: assert property (clk_en && !req.rd
		|=> rdata == READ_ZERO)
		else $error("read data without read");
	a_count_write: assert property (clk_en && wr_count
		|=> count == $past(req.wdata))
		else $error("count write lost");

	c_overflow: cover property (clk_en && overflow);
	c_event_overflow: cover property (clk_en && overflow && mode.source_select);
	c_pwm_wrap: cover property (clk_en && overflow && mode.pwm_output_enable);
	c_buzzer_on: cover property (buzzer_output_pin_oe && buzzer_output_pin);
	c_reload_wrap: cover property (clk_en && overflow && mode.reload_control);
endmodule

// file: include/tc_pkg.sv
// Constants, register layouts and types for the 8-bit timer/counter
// Notes on behaviour
// - Counter adds one per selected tick; outside PWM the wrap 0xFF to 0x00 is overflow.
// - Overflow keeps counting and raises a time-out that asks for interrupt service.
// - Source select 1 advances the counter once per falling edge on the event pin.
// - External event counting ignores the rate field and the fast clock select bit.
// - While event counting, the event pin's own request stays at zero.
// - Fast select 0: rate codes 000 to 111 give instruction clock over 256 down to 2.
// - Fast select 1: rate codes 000 to 111 give oscillator over 128 down to 1.
// - Counting happens only while the enable bit is 1.
// - PWM enable 1 drives a PWM output whose cycle comes from reload and toggle bits.
// - In PWM mode overflow is the selected PWM cycle boundary, 0xFF only for the 0-255 cycle.
// - PWM off and toggle bit 1: pin leaves general I/O, toggles every time-out.
// - PWM off: reload control 1 turns auto-reload on, 0 turns it off.
// - Source select 0 picks the internal clock, 1 picks the external event pin.
// - Green wake enable 1 lets a time-out wake the system; 0 blocks the wake.
// - Counter register is 8-bit read/write; software preloads 256 minus the interval.
// - With auto-reload on, every overflow copies the reload register into the counter.
// - PWM boundary: 00 gives 0-255, 01 gives 0-63, 10 gives 0-31, 11 gives 0-15.
// - Buzzer output runs at half the time-out rate, one change per time-out.
package tc_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_SHARED = 8'hD8;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 8'hDA;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'hDB;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD = 8'hCD;
	localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
	localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;
	localparam logic [DATA_W-1:0] COUNT_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	// PWM cycle boundaries indexed by {reload_control, toggle_output_enable}
	localparam logic [DATA_W-1:0] PWM_BOUND_00 = 8'hFF;
	localparam logic [DATA_W-1:0] PWM_BOUND_01 = 8'h3F;
	localparam logic [DATA_W-1:0] PWM_BOUND_10 = 8'h1F;
	localparam logic [DATA_W-1:0] PWM_BOUND_11 = 8'h0F;
	// Divide exponents: fcpu code 000 is /256, fosc code 000 is /128
	localparam logic [3:0] EXP_CPU_BASE = 4'h8;
	localparam logic [3:0] EXP_OSC_BASE = 4'h7;
	localparam int PRESC_W = 8;

	typedef struct packed {
		logic count_enable;
		logic [2:0] prescale_rate_field;
		logic source_select;
		logic reload_control;
		logic toggle_output_enable;
		logic pwm_output_enable;
	} mode_reg_t;

	typedef struct packed {
		logic other_timer_enable;
		logic [2:0] other_timer_rate_field;
		logic other_timer_fast_select;
		logic fast_clock_select;
		logic green_wake_enable;
		logic rtc_source_enable;
	} shared_reg_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// file: verilog/tc_edge_detect.sv
// Event pin synchroniser and falling edge detector
`timescale 1ns/10ps
module tc_edge_detect (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Pin and result
	input wire logic pin,
	output logic fall
);
	logic sync_a;
	logic sync_b;
	logic prev;

	always_ff @(posedge clk) begin
		if (reset) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			prev <= 1'b1;
		end else if (clk_en) begin
			sync_a <= pin;
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end

	// High sample followed by low sample
	assign fall = prev & ~sync_b;
endmodule

// file: verilog/tc_prescaler.sv
// Power-of-two prescaler producing a one-cycle tick
`timescale 1ns/10ps
module tc_prescaler
	import tc_pkg::*;
#(
	parameter int W = PRESC_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Control
	input wire logic run,
	input wire logic src_tick,
	input wire logic [3:0] exponent,
	// Result
	output logic tick
);
	logic [W-1:0] div_count;
	logic [W-1:0] low_mask;
	logic all_ones;

	function automatic logic [W-1:0] exp_mask(input logic [3:0] e);
		logic [W-1:0] m;
		m = '0;
		for (int i = 0; i < W; i++) begin
			if (i < int'(e)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	assign low_mask = exp_mask(exponent);
	assign all_ones = (div_count & low_mask) == low_mask;
	assign tick = run & src_tick & all_ones;

	always_ff @(posedge clk) begin
		if (reset) begin
			div_count <= '0;
		end else if (clk_en) begin
			if (!run) begin
				div_count <= '0;
			end else if (src_tick) begin
				div_count <= div_count + W'(1);
			end
		end
	end
endmodule

// file: test/event_source.sv
// Event pin source standing in for the outside world
`timescale 1ns/10ps
module event_source (
	// Clock and request
	input wire logic clk,
	input wire logic fire,
	// Pin
	output logic pin
);
	int low_left = 0;
	// Pulled up when idle; low for three cycles per event
	always @(posedge clk) begin
		if (fire)
			low_left <= 3;
		else if (low_left > 0)
			low_left <= low_left - 1;
	end
	assign pin = (low_left == 0);
endmodule

// file: test/tb.sv
// Self-checking bench for the 8-bit timer/counter
`timescale 1ns/10ps
module tb;
	import tc_pkg::*;
	logic clk = 0;
	logic reset = 1;
	logic wr = 0;
	logic rd = 0;
	logic fire = 0;
	logic clk_en = 1;
	logic cpu_tick = 0;
	int nhigh = 0;
	logic saw_req = 0;
	logic [7:0] addr = 0;
	logic [7:0] wdata = 0;
	logic [7:0] rdata, r, v, sh, m;
	logic pin, req, buz, oe, timeout, gw;
	int errors = 0;
	int checks = 0;
	int ntime = 0;
	int p, n0;
	logic [7:0] am [5] = '{ADDR_SHARED, ADDR_MODE, ADDR_COUNT, ADDR_RELOAD, 8'hE0};
	logic [7:0] tm [7] = '{8'hF0, 8'hE2, 8'hF4, 8'hF3, 8'hF5, 8'hF7, 8'hF1};

	timer_counter_8bit timer_counter_8bit_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
		.cpu_tick(cpu_tick), .osc_tick(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .external_event_pin(pin), .event_pin_request_flag(req),
		.buzzer_output_pin(buz), .buzzer_output_pin_oe(oe), .timeout(timeout),
		.green_wake(gw));
	event_source event_source_inst (.clk(clk), .fire(fire), .pin(pin));

	initial begin
		forever #10 clk = ~clk;
	end
	// Instruction clock pulse on every second clock
	always @(posedge clk) begin
		cpu_tick <= ~cpu_tick;
		if (buz === 1'b1)
			nhigh <= nhigh + 1;
		if (req === 1'b1)
			saw_req <= 1;
		if (timeout === 1'b1)
			ntime <= ntime + 1;
	end

	task report_and_stop;
		$display("Counts: %0d checks, %0d errors", checks, errors);
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (e !== s) begin
			errors++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask
	task wait_to(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (timeout !== 1'b1 && n < 9000);
		if (n >= 9000) begin
			chk("timeout wait", 0, 1);
			report_and_stop();
		end
	endtask
	// Cycles between time-outs; osc tick every clock, cpu tick every second clock
	function automatic int exp_per(logic [7:0] s, logic [7:0] c, logic [7:0] rl);
		int dv = s[2] ? 1 << (7 - c[6:4]) : 2 << (8 - c[6:4]);
		int t = 256;
		if (c[0])
			t = {c[2], c[1]} == 2'b00 ? 256 : 128 >> {c[2], c[1]};
		else if (c[2])
			t = 256 - rl;
		return dv * t;
	endfunction
	// High cycles per PWM cycle: reload value sets the duty within the cycle
	function automatic int exp_high(logic [7:0] s, logic [7:0] c, logic [7:0] rl);
		int t = {c[2], c[1]} == 2'b00 ? 256 : 128 >> {c[2], c[1]};
		return exp_per(s, c, rl) / t * (rl % t);
	endfunction
	task period(input logic [7:0] s, input logic [7:0] c, input logic [7:0] rl);
		logic b;
		int h;
		wr_reg(ADDR_MODE, 8'h00);
		wr_reg(ADDR_RELOAD, rl);
		wr_reg(ADDR_SHARED, s);
		wr_reg(ADDR_MODE, c);
		wait_to(p);
		b = buz;
		h = nhigh;
		chk("green_wake", s[1], gw);
		wait_to(p);
		chk("period", exp_per(s, c, rl), p);
		chk("pin_oe", c[0] | c[1], oe);
		if (!c[0])
			chk("buzzer", b ^ c[1], buz);
		else
			chk("pwm duty", exp_high(s, c, rl), nhigh - h);
		$display("Test mode %h shared %h done", c, s);
	endtask

	initial begin
		void'($urandom(79849));
		repeat (6) @(posedge clk);
		reset <= 0;
		foreach (am[i]) begin
			rd_reg(am[i], r);
			chk("reset value", 8'h00, r);
		end
		r = 8'($urandom);
		wr_reg(ADDR_MODE, 8'h70);
		wr_reg(ADDR_COUNT, r);
		repeat (20) @(posedge clk);
		rd_reg(ADDR_COUNT, v);
		chk("count held", r, v);
		rd_reg(ADDR_MODE, v);
		chk("mode", 8'h70, v);
		$display("Test registers done");
		// Frozen block ignores strobes and holds its count
		wr_reg(ADDR_SHARED, 8'h04);
		wr_reg(ADDR_COUNT, 8'h10);
		clk_en <= 0;
		wr_reg(ADDR_MODE, 8'hF0);
		repeat (10) @(posedge clk);
		clk_en <= 1;
		rd_reg(ADDR_COUNT, v);
		chk("frozen count", 8'h10, v);
		$display("Test freeze done");
		foreach (tm[i])
			period(i[0] ? 8'h06 : 8'h04, tm[i], 8'h80 | 8'($urandom));
		repeat (3) begin
			sh = 8'h02 | 8'(($urandom & 1) << 2);
			m = 8'h80 | 8'((5 + $urandom % 3) << 4) | 8'($urandom & 2);
			period(sh, m, 8'h00);
		end
		// Event counting with rate and fast bits set that must not matter
		wr_reg(ADDR_SHARED, 8'h04);
		wr_reg(ADDR_MODE, 8'h00);
		wr_reg(ADDR_COUNT, 8'hFE);
		wr_reg(ADDR_MODE, 8'hF8);
		n0 = ntime;
		repeat (30) @(posedge clk);
		rd_reg(ADDR_COUNT, r);
		chk("event idle", 8'hFE, r);
		repeat (2) begin
			fire <= 1;
			@(posedge clk);
			fire <= 0;
			repeat (8) @(posedge clk);
		end
		rd_reg(ADDR_COUNT, r);
		chk("event count", 8'h00, r);
		chk("event timeouts", 1, ntime - n0);
		chk("pin request", 1'b0, saw_req);
		wr_reg(ADDR_MODE, 8'h00);
		fire <= 1;
		@(posedge clk);
		fire <= 0;
		repeat (8) @(posedge clk);
		chk("pin request internal", 1'b1, saw_req);
		$display("Test events done");
		report_and_stop();
	end
endmodule
